// File: bcf_burst_config.sv
// Burst configuration word and burst read sequencer
`timescale 1ns/10ps
module bcf_burst_config
  import bcf_pkg::*;
(
  input  wire logic               clock,
  input  wire logic               sys_rst,
  input  wire logic               cfg_wr_en,
  input  wire logic [15:0]        cfg_wr_word,
  output logic      [15:0]        cfg_rd_word,
  input  wire logic               link_clk,
  input  wire bcf_pkg::bcf_req_s  link_req,
  output bcf_pkg::bcf_word_s      link_word,
  output logic                    rdy_pin
);
  import bcf_pkg::*;

  function automatic logic [5:0] len_words(input logic [2:0] code);
    case (code)
      LEN_8:   len_words = 6'h08;
      LEN_16:  len_words = 6'h10;
      LEN_32:  len_words = 6'h20;
      default: len_words = 6'h00;
    endcase
  endfunction

  // Address at offset ofs of a burst; wrap keeps the group's upper bits
  function automatic logic [ADDR_W-1:0] word_addr(
    input logic [ADDR_W-1:0] start,
    input logic [ADDR_W-1:0] ofs,
    input logic [5:0]        len,
    input logic              wrap);
    logic [ADDR_W-1:0] lin;
    logic [ADDR_W-1:0] msk;
    lin = start + ofs;
    msk = ADDR_W'(len) - ADDR_W'(1);
    if (wrap && len != IDX_ZERO)
      word_addr = (start & ~msk) | (lin & msk);
    else
      word_addr = lin;
  endfunction

  // System side: the word as software wrote it
  logic [15:0] cfg_q;
  logic [15:0] cfg_d;
  logic        tog_q;
  logic        tog_d;
  // The word handed to the link side stands in xfer_q until the link
  // echoes the toggle, so a write that lands while a hand-over is in
  // flight never shows the link a word in mid-change
  logic [15:0] xfer_q;
  logic [15:0] xfer_d;
  logic        ack_sys;
  logic        busy;

  always_comb
  begin
    cfg_d  = cfg_q;
    tog_d  = tog_q;
    xfer_d = xfer_q;
    busy   = tog_q != ack_sys;
    if (cfg_wr_en)
    begin
      cfg_d = cfg_wr_word;
    end
    // Start a hand-over only once the last one has been echoed
    if (!busy && xfer_q != cfg_q)
    begin
      xfer_d = cfg_q;
      tog_d  = ~tog_q;
    end
  end

  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      cfg_q  <= CFG_RESET;
      tog_q  <= 1'b0;
      xfer_q <= CFG_RESET;
    end
    else
    begin
      cfg_q  <= cfg_d;
      tog_q  <= tog_d;
      xfer_q <= xfer_d;
    end
  end

  assign cfg_rd_word = cfg_q;

  // Crossings between the domains; xfer_q holds still while its
  // toggle is in flight, so only the reset and the toggles need synchronising
  logic rst_link;
  logic tog_link;

  bcf_sync u_rst_sync
  (
    .clock (link_clk),
    .din   (sys_rst),
    .dout  (rst_link)
  );

  bcf_sync u_tog_sync
  (
    .clock (link_clk),
    .din   (tog_q),
    .dout  (tog_link)
  );

  // Link side, configuration copy: taken only when the toggle moves,
  // by which time xfer_q has stood for at least two link edges
  logic [15:0] lcfg_q;
  logic [15:0] lcfg_d;
  logic        ltog_q;
  logic        ltog_d;

  always_comb
  begin
    // The echo of ltog_q tells the system side the copy is taken
    lcfg_d = lcfg_q;
    ltog_d = tog_link;
    if (tog_link != ltog_q)
    begin
      lcfg_d = xfer_q;
    end
  end

  always_ff @(posedge link_clk)
  begin
    if (rst_link)
    begin
      lcfg_q <= CFG_RESET;
      ltog_q <= 1'b0;
    end
    else
    begin
      lcfg_q <= lcfg_d;
      ltog_q <= ltog_d;
    end
  end

  // Echo of the link toggle, back into the system domain
  bcf_sync u_ack_sync
  (
    .clock (clock),
    .din   (ltog_q),
    .dout  (ack_sys)
  );

  // Fields decoded from the link copy; they change only between
  // bursts, as the host writes the word before it starts reading
  logic [2:0] wait_code;
  logic [3:0] first_edge;
  logic [5:0] len;
  logic       early;
  logic       sync_mode;
  logic       wrap_on;
  logic       pol_high;

  always_comb
  begin
    wait_code  = lcfg_q[CFG_WAIT_HI:CFG_WAIT_LO];
    first_edge = {1'b0, wait_code} + WAIT_EDGE_OFS;
    len        = len_words(lcfg_q[CFG_LEN_HI:CFG_LEN_LO]);
    early      = !lcfg_q[CFG_RDYW_BIT]
                 && wait_code != 3'h0;
    sync_mode  = !lcfg_q[CFG_MODE_BIT];
    wrap_on    = lcfg_q[CFG_WRAP_BIT];
    pol_high   = lcfg_q[CFG_POL_BIT];
  end

  // Burst sequencer; ofs walks the whole address space so that a
  // continuous burst never folds back, idx is only compared for fixed lengths
  bcf_state_e        st_q;
  bcf_state_e        st_d;
  logic [3:0]        lat_q;
  logic [3:0]        lat_d;
  logic [5:0]        idx_q;
  logic [5:0]        idx_d;
  logic [ADDR_W-1:0] ofs_q;
  logic [ADDR_W-1:0] ofs_d;
  logic [ADDR_W-1:0] start_q;
  logic [ADDR_W-1:0] start_d;
  bcf_word_s         word_q;
  bcf_word_s         word_d;
  logic              rdy_q;
  logic              rdy_d;
  logic              rdy_act;

  always_comb
  begin
    st_d    = st_q;
    lat_d   = lat_q;
    idx_d   = idx_q;
    ofs_d   = ofs_q;
    start_d = start_q;
    word_d  = '{valid: 1'b0, addr: word_q.addr};
    rdy_act = !sync_mode;
    if (link_req.ce_n || !sync_mode)
    begin
      st_d = BCF_IDLE;
    end
    else if (!link_req.avd_n)
    begin
      st_d    = BCF_LAT;
      lat_d   = LAT_START;
      start_d = link_req.addr;
    end
    else
    begin
      case (st_q)
        BCF_LAT:
        begin
          // Longer wait gives the array more lead, so later words
          // then stream one per clock with no further stall
          if (lat_q == first_edge)
          begin
            st_d    = BCF_DATA;
            idx_d   = 6'h01;
            ofs_d   = ADDR_W'(1);
            word_d  = '{valid: 1'b1,
                        addr: word_addr(start_q, {ADDR_W{1'b0}}, len,
                                        wrap_on)};
            rdy_act = 1'b1;
          end
          else
          begin
            lat_d   = lat_q + 4'h1;
            rdy_act = early && (lat_q + 4'h1 == first_edge);
          end
        end
        BCF_DATA:
        begin
          if (len != IDX_ZERO && idx_q == len)
          begin
            st_d = BCF_IDLE;
          end
          else
          begin
            idx_d   = idx_q + 6'h01;
            ofs_d   = ofs_q + ADDR_W'(1);
            word_d  = '{valid: 1'b1,
                        addr: word_addr(start_q, ofs_q, len, wrap_on)};
            rdy_act = 1'b1;
          end
        end
        BCF_IDLE:
        begin
          st_d = BCF_IDLE;
        end
        default:
        begin
          st_d = BCF_IDLE;
        end
      endcase
    end
    // Idle level in sync mode is the inactive one; async shows ready
    rdy_d = rdy_act ~^ pol_high;
  end

  always_ff @(posedge link_clk)
  begin
    if (rst_link)
    begin
      // Ready shown active, as reads are asynchronous after reset
      st_q    <= BCF_IDLE;
      lat_q   <= LAT_START;
      idx_q   <= IDX_ZERO;
      ofs_q   <= '0;
      start_q <= '0;
      word_q  <= '0;
      rdy_q   <= 1'b1;
    end
    else
    begin
      st_q    <= st_d;
      lat_q   <= lat_d;
      idx_q   <= idx_d;
      ofs_q   <= ofs_d;
      start_q <= start_d;
      word_q  <= word_d;
      rdy_q   <= rdy_d;
    end
  end

  assign link_word = word_q;
  assign rdy_pin   = rdy_q;

endmodule // bcf_burst_config

// File: bcf_burst_config_props.sv
// Checker for the burst configuration word block
`timescale 1ns/10ps
module bcf_burst_config_props
  import bcf_pkg::*;
(
  input wire logic               clock,
  input wire logic               sys_rst,
  input wire logic               cfg_wr_en,
  input wire logic [15:0]        cfg_wr_word,
  input wire logic [15:0]        cfg_rd_word,
  input wire logic               link_clk,
  input wire bcf_pkg::bcf_req_s  link_req,
  input wire bcf_pkg::bcf_word_s link_word,
  input wire logic               rdy_pin
);
  logic [5:0] edge_q;
  logic [5:0] word_q;
  logic [5:0] len_n;
  logic [2:0] ws;
  assign ws = cfg_rd_word[13:11];
  always_comb
  begin
    case (cfg_rd_word[2:0])
      LEN_8:   len_n = 6'h08;
      LEN_16:  len_n = 6'h10;
      LEN_32:  len_n = 6'h20;
      default: len_n = 6'h00;
    endcase
  end
  // Wraps at 64, harmless: first words come within nine edges
  always_ff @(posedge link_clk)
  begin
    edge_q <= edge_q + 6'h01;
    word_q <= word_q + {5'h00, link_word.valid};
    if (!link_req.ce_n && !link_req.avd_n)
    begin
      edge_q <= 6'h00;
      word_q <= 6'h00;
    end
  end
  function automatic logic [23:0] nxt(logic [23:0] a);
    logic [23:0] m;
    m = {18'h0, len_n} - 24'h000001;
    if (cfg_rd_word[3] && len_n != 6'h00)
      return (a & ~m) | ((a + 24'h000001) & m);
    return a + 24'h000001;
  endfunction
  sequence s_first;
    $rose(link_word.valid);
  endsequence
  sequence s_two;
    link_word.valid ##1 link_word.valid;
  endsequence
  a_cfg_write: assert property (@(posedge clock) disable iff (sys_rst)
    cfg_wr_en |=> cfg_rd_word == $past(cfg_wr_word)) else $error("cfg lost");
  a_reset_value: assert property (@(posedge clock) disable iff (sys_rst)
    $fell(sys_rst) |-> cfg_rd_word == CFG_RESET) else $error("bad default");
  a_rdy_polarity: assert property (@(posedge link_clk) disable iff (sys_rst)
    link_word.valid |-> rdy_pin == cfg_rd_word[10]) else $error("rdy level");
  a_first_latency: assert property (@(posedge link_clk) disable iff (sys_rst)
    s_first |-> edge_q == {3'h0, ws} + 6'h02) else $error("first word edge");
  a_rdy_early: assert property (@(posedge link_clk) disable iff (sys_rst)
    s_first |-> ($past(rdy_pin) == cfg_rd_word[10]) ==
    (!cfg_rd_word[8] && ws != 3'h0)) else $error("rdy timing");
  a_wrap_order: assert property (@(posedge link_clk) disable iff (sys_rst)
    s_two |-> link_word.addr == nxt($past(link_word.addr)))
    else $error("addr order");
  a_burst_len: assert property (@(posedge link_clk) disable iff (sys_rst)
    $fell(link_word.valid) && len_n != 6'h00 |-> word_q == len_n)
    else $error("burst length");
  a_async_idle: assert property (@(posedge link_clk) disable iff (sys_rst)
    cfg_rd_word[15] && $past(cfg_rd_word[15], 6) |-> !link_word.valid &&
    rdy_pin == cfg_rd_word[10]) else $error("async burst");
endmodule // bcf_burst_config_props
bind bcf_burst_config bcf_burst_config_props u_props (.clock, .sys_rst,
  .cfg_wr_en, .cfg_wr_word, .cfg_rd_word, .link_clk, .link_req,
  .link_word, .rdy_pin);

// File: bcf_burst_config_tb.sv
// Self-checking bench for the burst configuration word block
`timescale 1ns/10ps
module bcf_burst_config_tb;
  import bcf_pkg::*;
  logic        clock = 1'b0;
  logic        link_clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic        cfg_wr_en = 1'b0;
  logic [15:0] cfg_wr_word = 16'h0000;
  logic [15:0] cfg_rd_word;
  bcf_req_s    link_req;
  bcf_word_s   link_word;
  logic        rdy_pin;
  logic [23:0] got[$];
  int          num_errors = 0;
  int          checks = 0;
  int          e = 0;
  int          first = 0;
  // Reserved bits at defaults, defined length codes only
  localparam logic [15:0] W[6] = '{16'hAFC8, 16'h1FCA, 16'h2AC3,
    16'h26CC, 16'h06C8, 16'hAFC8};
  localparam logic [7:0] A[6] = '{8'h10, 8'h3C, 8'h3C, 8'h45, 8'h7E, 8'h10};
  localparam logic [7:0] L[6] = '{8'h00, 8'h3B, 8'h4B, 8'h44, 8'h00, 8'h00};
  localparam int N[6] = '{0, 8, 16, 32, 1, 0};
  always #10 clock = ~clock;
  always #32 link_clk = ~link_clk;
  bcf_burst_config dut (.clock(clock), .sys_rst(sys_rst),
    .cfg_wr_en(cfg_wr_en), .cfg_wr_word(cfg_wr_word),
    .cfg_rd_word(cfg_rd_word), .link_clk(link_clk), .link_req(link_req),
    .link_word(link_word), .rdy_pin(rdy_pin));
  bcf_host_model host (.link_clk(link_clk), .link_req(link_req));
  always @(posedge link_clk)
  begin
    if (link_word.valid === 1'b1)
    begin
      if (got.size() == 0)
        first = e;
      got.push_back(link_word.addr);
    end
    e = link_req.avd_n ? e + 1 : 0;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic final_report;
    $display("checks %0d num_errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial
  begin
    repeat (10) @(posedge clock);
    #2 sys_rst = 1'b0;
    @(posedge clock);
    #2 check(cfg_rd_word, CFG_RESET);
    for (int i = 0; i < 6; i++)
    begin
      cfg_wr_en = 1'b1;
      cfg_wr_word = W[i];
      @(posedge clock);
      #2 cfg_wr_en = 1'b0;
      @(posedge clock);
      #2 check(cfg_rd_word, W[i]);
      // Link copy needs several link edges before a burst
      repeat (6) @(posedge link_clk);
      got.delete();
      host.burst({16'h0000, A[i]}, 48);
      repeat (4) @(posedge link_clk);
      if (N[i] == 0)
        check(got.size(), 0);
      else
      begin
        check(first, W[i][13:11] + 2);
        check(got[0], A[i]);
        if (N[i] > 1)
        begin
          check(got.size(), N[i]);
          check(got[$], L[i]);
        end
        else
          check(got[$], A[i] + got.size() - 1);
      end
      #2;
    end
    final_report();
  end
endmodule // bcf_burst_config_tb

// File: bcf_host_model.sv
// Host controller model issuing burst reads on the link clock
`timescale 1ns/10ps
module bcf_host_model
  import bcf_pkg::*;
(
  input  wire logic         link_clk,
  output bcf_pkg::bcf_req_s link_req
);
  initial link_req = '{ce_n: 1'b1, avd_n: 1'b1, addr: 24'h000000};
  task automatic burst(input logic [23:0] a, input int hold);
    @(posedge link_clk);
    #2 link_req = '{ce_n: 1'b0, avd_n: 1'b0, addr: a};
    @(posedge link_clk);
    // Address released after the latch, so show its inverse
    #2 link_req.avd_n = 1'b1;
    link_req.addr = ~a;
    repeat (hold) @(posedge link_clk);
    #2 link_req.ce_n = 1'b1;
  endtask
endmodule // bcf_host_model

// File: bcf_pkg.sv
// Constants and carriers for the burst configuration word block
package bcf_pkg;

  localparam int unsigned ADDR_W = 24;
  localparam int unsigned CFG_W  = 16;

  // Field positions of burst_config_word
  localparam int unsigned CFG_MODE_BIT  = 15;
  localparam int unsigned CFG_WAIT_HI   = 13;
  localparam int unsigned CFG_WAIT_LO   = 11;
  localparam int unsigned CFG_POL_BIT   = 10;
  localparam int unsigned CFG_RDYW_BIT  = 8;
  localparam int unsigned CFG_WRAP_BIT  = 3;
  localparam int unsigned CFG_LEN_HI    = 2;
  localparam int unsigned CFG_LEN_LO    = 0;

  // Value after power-up or hardware reset:
  // async, wait 101, active-high ready, ready with data, wrap, continuous
  localparam logic [15:0] CFG_RESET = 16'hAFC8;

  // Burst length codes
  localparam logic [2:0] LEN_CONT = 3'h0;
  localparam logic [2:0] LEN_8    = 3'h2;
  localparam logic [2:0] LEN_16   = 3'h3;
  localparam logic [2:0] LEN_32   = 3'h4;

  // First data valid on edge (wait code + WAIT_EDGE_OFS) after latch
  localparam logic [3:0] WAIT_EDGE_OFS = 4'h2;
  localparam logic [3:0] LAT_START     = 4'h1;
  localparam logic [5:0] IDX_ZERO      = 6'h00;

  typedef enum logic [2:0] {
    BCF_IDLE = 3'b001,
    BCF_LAT  = 3'b010,
    BCF_DATA = 3'b100
  } bcf_state_e;

  // Bus-side request from the host controller, on the link clock
  typedef struct packed {
    logic              ce_n;
    logic              avd_n;
    logic [ADDR_W-1:0] addr;
  } bcf_req_s;

  // Word address handed to the array, with its valid flag
  typedef struct packed {
    logic              valid;
    logic [ADDR_W-1:0] addr;
  } bcf_word_s;

endpackage

// File: bcf_sync.sv
// Two-flop level synchroniser
`timescale 1ns/10ps
module bcf_sync
(
  input  wire logic clock,
  input  wire logic din,
  output logic      dout
);
  logic meta_q;
  logic sync_q;

  always_ff @(posedge clock)
  begin
    meta_q <= din;
    sync_q <= meta_q;
  end

  assign dout = sync_q;
endmodule // bcf_sync
